// *** core/mpsc_pkg.sv ***
// Constants and carrier types for the module power and sleep control block
package mpsc_pkg;

  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned PWR_ON_MS     = 100;
  localparam int unsigned PWR_OFF_MS    = 2000;
  localparam int unsigned RESET_MS      = 1000;
  localparam int unsigned RESLEEP_MS    = 120_000;
  localparam int unsigned INIT_MS       = 50;
  localparam int unsigned RING_LOW_MS   = 30;
  localparam int unsigned RING_PER_MS   = 5000;
  localparam int unsigned SMS_LOW_MS    = 35;
  localparam int unsigned MSW           = 17;
  localparam logic [1:0]  LAMP_STYLE_RST = 2'h0;

  typedef enum logic [2:0] {
    MPSC_OFF, MPSC_INIT, MPSC_WORK, MPSC_DRAIN, MPSC_SLEEP, MPSC_SERVICE
  } mpsc_state_t;

  // Service events from the modem core
  typedef struct packed {
    logic call_in;
    logic call_answered;
    logic data_in;
    logic sms_in;
    logic busy;
    logic sleep_en;
  } mpsc_event_t;

  // Status shown to the modem core
  typedef struct packed {
    logic running;
    logic ready;
    logic asleep;
    logic wake_notify;
    logic core_reset;
  } mpsc_status_t;

endpackage : mpsc_pkg

// *** core/mpsc_ms_timer.sv ***
// Counter of millisecond ticks for low-level and state durations
`timescale 1ns/1ps
`default_nettype none
module mpsc_ms_timer #(
  parameter int unsigned W = 17
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         tick,
  input  wire logic         clear,
  output logic [W-1:0]      count
);

  // Saturating count of ticks since last clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (ce) begin
      if (clear) begin
        count <= '0;
      end else if (tick && count != {W{1'b1}}) begin
        count <= count + W'(1);
      end
    end
  end

endmodule : mpsc_ms_timer
`default_nettype wire

// *** core/mpsc_ctrl.sv ***
// Power key, reset, sleep handshake, ring and lamp control
`timescale 1ns/1ps
`default_nettype none
module mpsc_ctrl #(
  parameter int unsigned MS_CYC     = mpsc_pkg::MS_CYC,
  parameter int unsigned RESLEEP_MS = mpsc_pkg::RESLEEP_MS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 power_key_input_n,
  input  wire logic                 reset_input_n,
  input  wire logic                 sleep_request,
  input  wire mpsc_pkg::mpsc_event_t evt,
  input  wire logic [1:0]           lamp_style,
  input  wire logic                 lamp_style_we,
  output mpsc_pkg::mpsc_status_t    status_r,
  output logic                      io_supply_output,
  output logic                      ring_n,
  output logic                      network_status_lamp
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [2:0] meta_r;
  logic [2:0] sync_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
    end else if (ce) begin
      meta_r <= {power_key_input_n, reset_input_n, sleep_request};
      sync_r <= meta_r;
    end
  end

  logic key_low;
  logic rst_low;
  logic slp_req;
  assign key_low = !sync_r[2];
  assign rst_low = !sync_r[1];
  assign slp_req = sync_r[0];

  // ------------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------------
  localparam int unsigned PW = $clog2(MS_CYC);
  logic [PW-1:0] pre_r;
  logic          tick;

  assign tick = (pre_r == PW'(MS_CYC - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre_r <= '0;
    end else if (ce) begin
      pre_r <= tick ? '0 : pre_r + PW'(1);
    end
  end

  // ------------------------------------------------------------------
  // Low-time and state timers
  // ------------------------------------------------------------------
  localparam int unsigned W = mpsc_pkg::MSW;
  logic [W-1:0] key_ms;
  logic [W-1:0] rst_ms;
  logic [W-1:0] st_ms;
  logic         st_clr;
  logic         key_done_r;

  mpsc_ms_timer #(.W(W)) u_key (
    .clk_sys (clk_sys), .rstn (rstn), .ce (ce), .tick (tick),
    .clear   (!key_low), .count (key_ms)
  );
  mpsc_ms_timer #(.W(W)) u_rst (
    .clk_sys (clk_sys), .rstn (rstn), .ce (ce), .tick (tick),
    .clear   (!rst_low), .count (rst_ms)
  );
  mpsc_ms_timer #(.W(W)) u_st (
    .clk_sys (clk_sys), .rstn (rstn), .ce (ce), .tick (tick),
    .clear   (st_clr), .count (st_ms)
  );

  logic key_on;
  logic key_off;
  logic rst_hit;
  assign key_on  = key_ms > W'(mpsc_pkg::PWR_ON_MS);
  assign key_off = key_ms >= W'(mpsc_pkg::PWR_OFF_MS);
  assign rst_hit = rst_ms > W'(mpsc_pkg::RESET_MS);

  // ------------------------------------------------------------------
  // Power and sleep state machine
  // ------------------------------------------------------------------
  mpsc_pkg::mpsc_state_t st_r;
  mpsc_pkg::mpsc_state_t st_nxt;
  logic wake_evt;
  assign wake_evt = evt.call_in | evt.data_in | evt.sms_in;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      mpsc_pkg::MPSC_OFF:
        if (key_on && !key_done_r) st_nxt = mpsc_pkg::MPSC_INIT;
      mpsc_pkg::MPSC_INIT:
        if (st_ms >= W'(mpsc_pkg::INIT_MS)) st_nxt = mpsc_pkg::MPSC_WORK;
      mpsc_pkg::MPSC_WORK:
        if (evt.sleep_en && !slp_req) st_nxt = mpsc_pkg::MPSC_DRAIN;
      mpsc_pkg::MPSC_DRAIN:
        if (slp_req) st_nxt = mpsc_pkg::MPSC_WORK;
        else if (!evt.busy) st_nxt = mpsc_pkg::MPSC_SLEEP;
      mpsc_pkg::MPSC_SLEEP:
        if (slp_req) st_nxt = mpsc_pkg::MPSC_WORK;
        else if (wake_evt) st_nxt = mpsc_pkg::MPSC_SERVICE;
      mpsc_pkg::MPSC_SERVICE:
        if (slp_req) st_nxt = mpsc_pkg::MPSC_WORK;
        else if (!evt.busy && st_ms >= W'(RESLEEP_MS))
          st_nxt = mpsc_pkg::MPSC_SLEEP;
      default: st_nxt = mpsc_pkg::MPSC_OFF;
    endcase
    if (st_r != mpsc_pkg::MPSC_OFF && key_off && !key_done_r)
      st_nxt = mpsc_pkg::MPSC_OFF;
    if (st_r != mpsc_pkg::MPSC_OFF && rst_hit)
      st_nxt = mpsc_pkg::MPSC_INIT;
  end

  // Service time counts from the end of processing
  assign st_clr = (st_nxt != st_r) ||
                  (st_r == mpsc_pkg::MPSC_SERVICE && evt.busy);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= mpsc_pkg::MPSC_OFF;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // One action per key press
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      key_done_r <= 1'b0;
    end else if (ce) begin
      if (!key_low) key_done_r <= 1'b0;
      else if (st_nxt != st_r && (key_on || key_off)) key_done_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Status and IO supply
  // ------------------------------------------------------------------
  logic on_nxt;
  assign on_nxt = st_nxt != mpsc_pkg::MPSC_OFF;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_r         <= '0;
      io_supply_output <= 1'b0;
    end else if (ce) begin
      io_supply_output   <= on_nxt && st_nxt != mpsc_pkg::MPSC_SLEEP;
      status_r.running   <= on_nxt;
      status_r.ready     <= on_nxt && st_nxt != mpsc_pkg::MPSC_INIT;
      status_r.asleep    <= st_nxt == mpsc_pkg::MPSC_SLEEP;
      status_r.wake_notify <= st_r == mpsc_pkg::MPSC_SLEEP &&
                              st_nxt == mpsc_pkg::MPSC_SERVICE;
      status_r.core_reset <= st_nxt == mpsc_pkg::MPSC_INIT;
    end
  end

  // ------------------------------------------------------------------
  // Ring indicator
  // ------------------------------------------------------------------
  logic [12:0] ring_ms_r;
  logic        ringing_r;
  logic [5:0]  sms_ms_r;
  logic        on_now;
  assign on_now = st_r != mpsc_pkg::MPSC_OFF;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ringing_r <= 1'b0;
      ring_ms_r <= '0;
    end else if (ce) begin
      if (!on_now || evt.call_answered || !evt.call_in) begin
        ringing_r <= 1'b0;
        ring_ms_r <= '0;
      end else begin
        ringing_r <= 1'b1;
        // Count only once ringing, so the first low lasts a full 30 ticks
        if (tick && ringing_r) begin
          ring_ms_r <= (ring_ms_r == 13'(mpsc_pkg::RING_PER_MS - 1)) ?
                       '0 : ring_ms_r + 13'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sms_ms_r <= '0;
    end else if (ce) begin
      if (on_now && evt.sms_in && sms_ms_r == '0) begin
        sms_ms_r <= 6'(mpsc_pkg::SMS_LOW_MS);
      end else if (tick && sms_ms_r != '0) begin
        sms_ms_r <= sms_ms_r - 6'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ring_n <= 1'b1;
    end else if (ce) begin
      ring_n <= !((ringing_r &&
                   ring_ms_r < 13'(mpsc_pkg::RING_LOW_MS)) ||
                  sms_ms_r != '0);
    end
  end

  // ------------------------------------------------------------------
  // Network status lamp
  // ------------------------------------------------------------------
  logic [1:0]  style_r;
  logic [11:0] lamp_ms_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      style_r   <= mpsc_pkg::LAMP_STYLE_RST;
      lamp_ms_r <= '0;
    end else if (ce) begin
      if (lamp_style_we) style_r <= lamp_style;
      if (tick) lamp_ms_r <= lamp_ms_r + 12'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      network_status_lamp <= 1'b0;
    end else if (ce) begin
      if (!on_now) begin
        network_status_lamp <= 1'b0;
      end else begin
        case (style_r)
          2'h0: network_status_lamp <= status_r.asleep ? lamp_ms_r[11]
                                      : lamp_ms_r[9];
          2'h1: network_status_lamp <= lamp_ms_r[8];
          2'h2: network_status_lamp <= 1'b1;
          default: network_status_lamp <= 1'b0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  ring_idle_high_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (!on_now && $past(!on_now) && sms_ms_r == '0) |=> ring_n)
    else $error("ring low while idle");

  supply_off_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (st_r == mpsc_pkg::MPSC_OFF) |-> !io_supply_output)
    else $error("io supply on while off");

  sleep_supply_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (st_r == mpsc_pkg::MPSC_SLEEP) |-> !io_supply_output)
    else $error("io supply on while asleep");

  drain_wait_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && st_r == mpsc_pkg::MPSC_DRAIN && evt.busy && !rst_hit)
      |=> st_r != mpsc_pkg::MPSC_SLEEP)
    else $error("sleep entered while busy");

  wake_request_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && st_r == mpsc_pkg::MPSC_SLEEP && slp_req && !key_off && !rst_hit)
      |=> st_r == mpsc_pkg::MPSC_WORK)
    else $error("sleep request high did not wake");

  event_wake_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && st_r == mpsc_pkg::MPSC_SLEEP && !slp_req && wake_evt &&
     !key_off && !rst_hit) |=> status_r.wake_notify)
    else $error("wake event without notification");

  power_on_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && st_r == mpsc_pkg::MPSC_OFF && key_on && !key_done_r)
      |=> st_r == mpsc_pkg::MPSC_INIT)
    else $error("no power on after long key press");

  power_off_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && st_r != mpsc_pkg::MPSC_OFF && key_off && !key_done_r && !rst_hit)
      |=> st_r == mpsc_pkg::MPSC_OFF)
    else $error("no power off after 2 s key press");

  answered_high_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && evt.call_answered && sms_ms_r == '0) ##1
    (ce && sms_ms_r == '0) |=> ring_n)
    else $error("ring low after answer");

endmodule : mpsc_ctrl
`default_nettype wire

// *** verification/mpsc_host_model.sv ***
// Host microcontroller model driving the module control pins
`timescale 1ns/1ps
`default_nettype none
module mpsc_host_model #(
  parameter int unsigned MS_CYC = 10
) (
  input  wire logic clk_sys,
  output logic      power_key_input_n,
  output logic      reset_input_n,
  output logic      sleep_request
);
  initial begin
    power_key_input_n = 1'b1;
    reset_input_n     = 1'b1;
    sleep_request     = 1'b1;
  end

  // Low for whole ms, then back to the pull-up level
  task automatic hold_ms(input int ms, input bit is_key);
    @(posedge clk_sys);
    #1;
    if (is_key) power_key_input_n = 1'b0;
    else reset_input_n = 1'b0;
    repeat (ms * MS_CYC) @(posedge clk_sys);
    #1;
    power_key_input_n = 1'b1;
    reset_input_n     = 1'b1;
  endtask : hold_ms

  task automatic set_key(input logic v);
    @(posedge clk_sys);
    #1;
    power_key_input_n = v;
  endtask : set_key

  task automatic set_req(input logic v);
    @(posedge clk_sys);
    #1;
    sleep_request = v;
  endtask : set_req
endmodule : mpsc_host_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the power and sleep control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned MSC = 10;
  localparam int unsigned RSL = 20;
  logic                   clk_sys, rstn, ce, key_n, rst_in_n, sreq;
  logic                   lamp_we, io, ring_n, lamp;
  logic [1:0]             lamp_style;
  mpsc_pkg::mpsc_event_t  evt;
  mpsc_pkg::mpsc_status_t st;
  int                     fail_count, n_tests, m_on, m_asleep, w, h0, h1;
  logic [31:0]            seed;

  mpsc_host_model #(.MS_CYC(MSC)) host (
    .clk_sys(clk_sys), .power_key_input_n(key_n),
    .reset_input_n(rst_in_n), .sleep_request(sreq));

  mpsc_ctrl #(.MS_CYC(MSC), .RESLEEP_MS(RSL)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .power_key_input_n(key_n),
    .reset_input_n(rst_in_n), .sleep_request(sreq), .evt(evt),
    .lamp_style(lamp_style), .lamp_style_we(lamp_we), .status_r(st),
    .io_supply_output(io), .ring_n(ring_n), .network_status_lamp(lamp));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : step

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Model state against the outputs
  task automatic check_state();
    check("running", st.running, m_on);
    check("ready", st.ready, m_on);
    check("asleep", st.asleep, m_asleep);
    check("io_supply", io, m_on != 0 && m_asleep == 0);
  endtask : check_state

  // Width in ms of the next ring low pulse
  task automatic low_width(output int ms);
    int n;
    n = 0;
    for (int i = 0; i < 100 * MSC && ring_n === 1'b1; i++) step(1);
    while (ring_n === 1'b0 && n < 100 * MSC) begin
      step(1);
      n++;
    end
    ms = (n + MSC - 1) / MSC;
  endtask : low_width

  // Time in ms that the lamp holds one level
  task automatic lamp_half(output int ms);
    logic v;
    int   n;
    n = 0;
    v = lamp;
    for (int i = 0; i < 600 * MSC && lamp === v; i++) step(1);
    v = lamp;
    while (lamp === v && n < 600 * MSC) begin
      step(1);
      n++;
    end
    ms = (n + MSC - 1) / MSC;
  endtask : lamp_half

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (95000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end

  initial begin
    {rstn, lamp_we, lamp_style, m_on, m_asleep} = '0;
    {fail_count, n_tests} = '0;
    ce = 1'b1;
    evt = '0;
    seed = 32'ha275eaff;
    step(12);
    rstn = 1'b1;
    step(2);
    check_state();
    check("ring", ring_n, 1'b1);
    check("lamp", lamp, 1'b0);
    host.hold_ms(20 + int'(rnd() % 70), 1'b1);
    step(20 * MSC);
    check_state();
    host.hold_ms(210 + int'(rnd() % 50), 1'b1);
    m_on = 1;
    step(60 * MSC);
    check_state();
    $display("test power_on done");
    lamp_half(h0);
    lamp_style = 2'h1;
    lamp_we = 1'b1;
    step(1);
    lamp_we = 1'b0;
    lamp_half(h1);
    check("lamp_fast", h0 > 0 && h1 > 0 && h1 < h0, 1'b1);
    for (int s = 2; s < 4; s++) begin
      lamp_style = 2'(s);
      lamp_we = 1'b1;
      step(1);
      lamp_we = 1'b0;
      step(3);
      check("lamp", lamp, s == 2);
    end
    $display("test lamp done");
    evt.sleep_en = 1'b1;
    ce = 1'b0;
    host.set_req(1'b0);
    step(5 * MSC);
    check_state();
    ce = 1'b1;
    m_asleep = 1;
    step(5 * MSC);
    check_state();
    host.set_req(1'b1);
    m_asleep = 0;
    step(5 * MSC);
    check_state();
    $display("test clock_enable done");
    evt.busy = 1'b1;
    host.set_req(1'b0);
    step(20 * MSC);
    check_state();
    evt.busy = 1'b0;
    m_asleep = 1;
    step(5 * MSC);
    check_state();
    host.set_req(1'b1);
    m_asleep = 0;
    step(5 * MSC);
    check_state();
    host.set_req(1'b0);
    m_asleep = 1;
    step(5 * MSC);
    check_state();
    evt.data_in = 1'b1;
    w = 0;
    for (int i = 0; i < 20; i++) begin
      step(1);
      if (st.wake_notify === 1'b1) w = 1;
    end
    evt.data_in = 1'b0;
    check("wake_notify", w, 1);
    m_asleep = 0;
    step(RSL / 2 * MSC);
    check_state();
    m_asleep = 1;
    step(RSL * MSC);
    check_state();
    host.set_req(1'b1);
    m_asleep = 0;
    step(5 * MSC);
    $display("test sleep done");
    evt.sms_in = 1'b1;
    step(1);
    evt.sms_in = 1'b0;
    low_width(w);
    check("sms_low_ms", w, mpsc_pkg::SMS_LOW_MS);
    step(10 * MSC);
    check("ring", ring_n, 1'b1);
    evt.call_in = 1'b1;
    low_width(w);
    check("call_low_ms", w, mpsc_pkg::RING_LOW_MS);
    evt.call_in = 1'b0;
    step(10 * MSC);
    evt.call_in = 1'b1;
    for (int i = 0; i < 100 && ring_n === 1'b1; i++) step(1);
    step(10 * MSC);
    evt.call_answered = 1'b1;
    step(2 * MSC);
    w = 0;
    for (int i = 0; i < 200 * MSC; i++) begin
      step(1);
      if (ring_n !== 1'b1) w++;
    end
    check("ring_answered_lows", w, 0);
    evt = '0;
    $display("test ring done");
    host.hold_ms(900, 1'b0);
    step(2 * MSC);
    check("core_reset", st.core_reset, 1'b0);
    host.hold_ms(1030, 1'b0);
    check("core_reset", st.core_reset, 1'b1);
    step(60 * MSC);
    check_state();
    $display("test reset_pin done");
    host.hold_ms(2100, 1'b1);
    m_on = 0;
    step(5);
    check_state();
    check("lamp", lamp, 1'b0);
    check("ring", ring_n, 1'b1);
    $display("test power_off done");
    rstn = 1'b0;
    host.set_key(1'b0);
    step(12);
    rstn = 1'b1;
    m_on = 1;
    step(2100 * MSC);
    host.set_key(1'b1);
    step(5 * MSC);
    check_state();
    $display("test auto_start done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
